// file: hw/oas_core.sv
/*
 Operand effective address generation and program status word.
 Assumes the decoder presents one request per cycle; results are
 registered one cycle later. Interrupt pending latches are kept here.
*/
`timescale 1ns/100ps
`include "oas_params.svh"
// Summary of operation
// - Direct mode: 8-bit field addresses register file
// - Up to three direct operands per instruction
// - Indirect: address from selected word register
// - Auto-increment pointer by one or two
// - Immediate: 8-bit byte, 16-bit word field
// - Short index: sign-extended 8-bit displacement plus base
// - Long index: 16-bit displacement plus base
// - Lowest two register bytes always zero
// - Stack pointer lives at register 18h
// - Status low byte is interrupt mask
// - Mask bit one permits its source
// - Bit 9 gates all interrupts
// - Requests latch pending while masked
// - Whole status word pushed and popped
// - Zero flag; chained ops only clear
// - Negative flag is true algebraic sign
// - Overflow on range; left shift msb change
// - Trap flag sticky until explicit clear
// - Carry out; borrow gives carry zero
// - Round hint on right shift one out
// - Flag bit positions 15..11, 9, 8
// - Words little-endian at even address
module oas_core #(
   parameter int NUM_SRC = 8
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire oas_pkg::oas_addr_req_s addr_req_in,
   output logic [15:0] eff_addr_out,
   output logic [15:0] operand_out,
   output logic is_memory_out,
   output logic addr_valid_out,
   input wire logic [7:0] rd_b_addr_in,
   input wire logic [7:0] rd_c_addr_in,
   output logic [15:0] rd_b_data_out,
   output logic [15:0] rd_c_data_out,
   input wire logic wr_en_in,
   input wire logic wr_word_in,
   input wire logic [7:0] wr_addr_in,
   input wire logic [15:0] wr_data_in,
   input wire oas_pkg::oas_flag_upd_s flag_upd_in,
   input wire logic trap_clear_in,
   input wire logic psw_pop_in,
   input wire logic [15:0] psw_pop_data_in,
   input wire logic gate_write_in,
   input wire logic gate_value_in,
   output logic [15:0] psw_out,
   input wire logic [NUM_SRC-1:0] irq_req_in,
   input wire logic [NUM_SRC-1:0] irq_ack_in,
   output logic [NUM_SRC-1:0] irq_pending_out,
   output logic [NUM_SRC-1:0] irq_service_out,
   output logic irq_take_out
);
   if (NUM_SRC != 8) begin : g_bad_src
      $error("oas_core needs NUM_SRC 8");
   end

   logic [15:0] base_word;
   logic [15:0] rf_rd_a_data;
   logic rf_wr_en;
   logic rf_wr_word;
   logic [7:0] rf_wr_addr;
   logic [15:0] rf_wr_data;
   logic [15:0] ea_nxt;
   logic [15:0] opnd_nxt;
   logic mem_nxt;
   logic autoinc_wr;
   logic [15:0] autoinc_val;
   logic [15:0] psw_word;
   logic flag_upd_take;
   logic zero_r;
   logic neg_r;
   logic ovf_r;
   logic trap_r;
   logic carry_r;
   logic gate_r;
   logic round_r;
   logic [7:0] mask_r;
   logic [7:0] mask_byte;
   logic [NUM_SRC-1:0] pending_r;
   logic [NUM_SRC-1:0] service_nxt;

   function automatic logic [15:0] sext8(input logic [7:0] v);
      sext8 = {{8{v[7]}}, v};
   endfunction : sext8

   function automatic logic hits_mask(input logic [7:0] a, input logic w);
      hits_mask = (a == `OAS_INT_MASK_ADDR) || (w && (a & 8'hfe) == `OAS_INT_MASK_ADDR);
   endfunction : hits_mask

   oas_regfile #(
      .DEPTH(256)
   ) u_regfile (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .rd_a_addr_in(addr_req_in.reg_sel),
      .rd_b_addr_in(rd_b_addr_in),
      .rd_c_addr_in(rd_c_addr_in),
      .rd_a_data_out(rf_rd_a_data),
      .rd_b_data_out(rd_b_data_out),
      .rd_c_data_out(rd_c_data_out),
      .wr_en_in(rf_wr_en),
      .wr_word_in(rf_wr_word),
      .wr_addr_in(rf_wr_addr),
      .wr_data_in(rf_wr_data)
   );

   // The stack pointer at 18h is an ordinary word of the file, so it
   // serves as base for indirect and indexed access
   assign base_word = rf_rd_a_data;

   always_comb begin
      ea_nxt = 16'h0000;
      opnd_nxt = 16'h0000;
      mem_nxt = 1'b0;
      autoinc_wr = 1'b0;
      autoinc_val = base_word;
      unique case (addr_req_in.mode)
         oas_pkg::OAS_MODE_DIRECT: begin
            ea_nxt = {8'h00, addr_req_in.reg_sel};
            opnd_nxt = base_word;
         end
         oas_pkg::OAS_MODE_INDIRECT: begin
            ea_nxt = base_word;
            mem_nxt = 1'b1;
         end
         oas_pkg::OAS_MODE_AUTOINC: begin
            ea_nxt = base_word;
            mem_nxt = 1'b1;
            autoinc_wr = addr_req_in.valid;
            autoinc_val = base_word + (addr_req_in.is_word ? `OAS_STEP_WORD
                                                            : `OAS_STEP_BYTE);
         end
         oas_pkg::OAS_MODE_IMMEDIATE: begin
            opnd_nxt = addr_req_in.is_word ? addr_req_in.field
                                           : {8'h00, addr_req_in.field[7:0]};
         end
         oas_pkg::OAS_MODE_SHORT_IDX: begin
            ea_nxt = base_word + sext8(addr_req_in.field[7:0]);
            mem_nxt = 1'b1;
         end
         oas_pkg::OAS_MODE_LONG_IDX: begin
            // Zero register as base gives an absolute address
            ea_nxt = base_word + addr_req_in.field;
            mem_nxt = 1'b1;
         end
         default: begin
            ea_nxt = 16'h0000;
         end
      endcase
   end

   // Pointer bump takes the write port over the decoder
   always_comb begin
      if (autoinc_wr) begin
         rf_wr_en = 1'b1;
         rf_wr_word = 1'b1;
         rf_wr_addr = addr_req_in.reg_sel;
         rf_wr_data = autoinc_val;
      end else begin
         rf_wr_en = wr_en_in;
         rf_wr_word = wr_word_in;
         rf_wr_addr = wr_addr_in;
         rf_wr_data = wr_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         eff_addr_out <= 16'h0000;
         operand_out <= 16'h0000;
         is_memory_out <= 1'b0;
         addr_valid_out <= 1'b0;
      end else begin
         eff_addr_out <= ea_nxt;
         operand_out <= opnd_nxt;
         is_memory_out <= mem_nxt;
         addr_valid_out <= addr_req_in.valid;
      end
   end

   // An update with no flag operation leaves every flag alone
   assign flag_upd_take = flag_upd_in.valid && (flag_upd_in.op != oas_pkg::OAS_FLAG_NONE);

   // Zero flag; chained ops can only clear it
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         zero_r <= 1'b0;
      end else if (psw_pop_in) begin
         zero_r <= psw_pop_data_in[`OAS_PSW_ZERO_BIT];
      end else if (flag_upd_take) begin
         if (flag_upd_in.op == oas_pkg::OAS_FLAG_ARITH_CHAIN) begin
            if (flag_upd_in.result != 16'h0000) begin
               zero_r <= 1'b0;
            end
         end else begin
            zero_r <= (flag_upd_in.result == 16'h0000);
         end
      end
   end

   // Negative, overflow and carry follow the ALU
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         neg_r <= 1'b0;
         ovf_r <= 1'b0;
         carry_r <= 1'b0;
      end else if (psw_pop_in) begin
         neg_r <= psw_pop_data_in[`OAS_PSW_NEG_BIT];
         ovf_r <= psw_pop_data_in[`OAS_PSW_OVF_BIT];
         carry_r <= psw_pop_data_in[`OAS_PSW_CARRY_BIT];
      end else if (flag_upd_take) begin
         neg_r <= flag_upd_in.negative;
         ovf_r <= flag_upd_in.overflow;
         // ALU supplies carry already as not-borrow
         carry_r <= flag_upd_in.carry;
      end
   end

   // Trap flag: set wins over a same-cycle clear
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         trap_r <= 1'b0;
      end else if (psw_pop_in) begin
         trap_r <= psw_pop_data_in[`OAS_PSW_TRAP_BIT];
      end else if (flag_upd_take && flag_upd_in.overflow) begin
         trap_r <= 1'b1;
      end else if (trap_clear_in) begin
         trap_r <= 1'b0;
      end
   end

   // Round hint; multiply leaves it cleared
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         round_r <= 1'b0;
      end else if (psw_pop_in) begin
         round_r <= psw_pop_data_in[`OAS_PSW_ROUND_BIT];
      end else if (flag_upd_take) begin
         if (flag_upd_in.op == oas_pkg::OAS_FLAG_SHIFT_RIGHT) begin
            round_r <= flag_upd_in.round_hint;
         end else if (flag_upd_in.op == oas_pkg::OAS_FLAG_MULTIPLY) begin
            round_r <= 1'b0;
         end
      end
   end

   // Global interrupt gate
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         gate_r <= 1'b0;
      end else if (psw_pop_in) begin
         gate_r <= psw_pop_data_in[`OAS_PSW_GATE_BIT];
      end else if (gate_write_in) begin
         gate_r <= gate_value_in;
      end
   end

   // Mask byte mirrors whatever the file port writes to 08h
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         mask_r <= 8'h00;
      end else if (psw_pop_in) begin
         mask_r <= psw_pop_data_in[7:0];
      end else if (rf_wr_en && hits_mask(rf_wr_addr, rf_wr_word)) begin
         mask_r <= rf_wr_data[7:0];
      end
   end

   // Bit 10 is unused and reads as zero
   always_comb begin
      psw_word = `OAS_PSW_RESET;
      psw_word[`OAS_PSW_ZERO_BIT] = zero_r;
      psw_word[`OAS_PSW_NEG_BIT] = neg_r;
      psw_word[`OAS_PSW_OVF_BIT] = ovf_r;
      psw_word[`OAS_PSW_TRAP_BIT] = trap_r;
      psw_word[`OAS_PSW_CARRY_BIT] = carry_r;
      psw_word[`OAS_PSW_GATE_BIT] = gate_r;
      psw_word[`OAS_PSW_ROUND_BIT] = round_r;
      psw_word[7:0] = mask_r;
   end

   assign mask_byte = mask_r;
   assign psw_out = psw_word;

   // Pending latches regardless of mask; new request beats ack
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pending_r <= '0;
      end else begin
         pending_r <= irq_req_in | (pending_r & ~irq_ack_in);
      end
   end

   // Lowest-numbered enabled source has priority
   always_comb begin
      service_nxt = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (pending_r[i] && mask_byte[i] && gate_r) begin
            service_nxt = '0;
            service_nxt[i] = 1'b1;
         end
      end
   end

   assign irq_pending_out = pending_r;
   assign irq_service_out = service_nxt;
   assign irq_take_out = |service_nxt;
endmodule : oas_core

// file: hw/oas_params.svh
/*
 Register file offsets, status word field positions and reset values.
 Assumes inclusion by bare name from the design modules.
*/
`ifndef OAS_PARAMS_SVH
`define OAS_PARAMS_SVH
`define OAS_ZERO_REG_ADDR 8'h00
`define OAS_INT_MASK_ADDR 8'h08
`define OAS_STACK_PTR_ADDR 8'h18
`define OAS_PSW_ZERO_BIT 15
`define OAS_PSW_NEG_BIT 14
`define OAS_PSW_OVF_BIT 13
`define OAS_PSW_TRAP_BIT 12
`define OAS_PSW_CARRY_BIT 11
`define OAS_PSW_GATE_BIT 9
`define OAS_PSW_ROUND_BIT 8
`define OAS_PSW_RESET 16'h0000
`define OAS_STEP_BYTE 16'h0001
`define OAS_STEP_WORD 16'h0002
`endif

// file: hw/oas_pkg.sv
/*
 Types shared by the operand address and status flag logic.
 Assumes the params header sits on the include path.
*/
package oas_pkg;
   typedef enum logic [2:0] {
      OAS_MODE_DIRECT,
      OAS_MODE_INDIRECT,
      OAS_MODE_AUTOINC,
      OAS_MODE_IMMEDIATE,
      OAS_MODE_SHORT_IDX,
      OAS_MODE_LONG_IDX
   } oas_mode_e;

   typedef enum logic [2:0] {
      OAS_FLAG_NONE,
      OAS_FLAG_ARITH,
      OAS_FLAG_ARITH_CHAIN,
      OAS_FLAG_SHIFT_LEFT,
      OAS_FLAG_SHIFT_RIGHT,
      OAS_FLAG_MULTIPLY,
      OAS_FLAG_LOGIC
   } oas_flag_op_e;

   typedef struct packed {
      logic valid;
      oas_mode_e mode;
      logic is_word;
      logic [7:0] reg_sel;
      logic [15:0] field;
   } oas_addr_req_s;

   typedef struct packed {
      logic valid;
      oas_flag_op_e op;
      logic [15:0] result;
      logic zero;
      logic negative;
      logic overflow;
      logic carry;
      logic round_hint;
   } oas_flag_upd_s;
endpackage : oas_pkg

// file: hw/oas_regfile.sv
/*
 256-byte on-chip register file with three read ports and one write port.
 Assumes single clock, synchronous reset; word accesses are aligned.
*/
`timescale 1ns/100ps
`include "oas_params.svh"
module oas_regfile #(
   parameter int DEPTH = 256
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] rd_a_addr_in,
   input wire logic [7:0] rd_b_addr_in,
   input wire logic [7:0] rd_c_addr_in,
   output logic [15:0] rd_a_data_out,
   output logic [15:0] rd_b_data_out,
   output logic [15:0] rd_c_data_out,
   input wire logic wr_en_in,
   input wire logic wr_word_in,
   input wire logic [7:0] wr_addr_in,
   input wire logic [15:0] wr_data_in
);
   if (DEPTH != 256) begin : g_bad_depth
      $error("oas_regfile needs DEPTH 256");
   end

   logic [7:0] mem_r [DEPTH];

   function automatic logic [15:0] rd_word(input logic [7:0] a);
      logic [7:0] hi;
      hi = a | 8'h01;
      rd_word = {mem_r[hi], mem_r[a & 8'hfe]};
   endfunction : rd_word

   function automatic logic is_zero_reg(input logic [7:0] a);
      is_zero_reg = ({a[7:1], 1'b0} == `OAS_ZERO_REG_ADDR);
   endfunction : is_zero_reg

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= 8'h00;
         end
      end else if (wr_en_in) begin
         if (wr_word_in) begin
            if (!is_zero_reg(wr_addr_in)) begin
               mem_r[wr_addr_in & 8'hfe] <= wr_data_in[7:0];
               mem_r[wr_addr_in | 8'h01] <= wr_data_in[15:8];
            end
         end else if (!is_zero_reg(wr_addr_in)) begin
            mem_r[wr_addr_in] <= wr_data_in[7:0];
         end
      end
   end

   // Three ports serve up to three direct operands
   assign rd_a_data_out = rd_word(rd_a_addr_in);
   assign rd_b_data_out = rd_word(rd_b_addr_in);
   assign rd_c_data_out = rd_word(rd_c_addr_in);
endmodule : oas_regfile

// file: verif/oas_monitor.sv
/*
 Concurrent checks on the operand address and status word block.
 Assumes a bind from the bench top; one clock, synchronous reset.
*/
`timescale 1ns/100ps
module oas_monitor #(
   parameter int NUM_SRC = 8
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] rd_b_addr_in,
   input wire logic [15:0] rd_b_data_out,
   input wire oas_pkg::oas_flag_upd_s flag_upd_in,
   input wire logic trap_clear_in,
   input wire logic psw_pop_in,
   input wire logic [15:0] psw_pop_data_in,
   input wire logic gate_write_in,
   input wire logic [15:0] psw_out,
   input wire logic [NUM_SRC-1:0] irq_req_in,
   input wire logic [NUM_SRC-1:0] irq_pending_out,
   input wire logic [NUM_SRC-1:0] irq_service_out,
   input wire logic irq_take_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   sequence s_upd;
      flag_upd_in.valid && !psw_pop_in;
   endsequence
   sequence s_arith;
      s_upd ##0 flag_upd_in.op == oas_pkg::OAS_FLAG_ARITH;
   endsequence
   AST_ZERO_READ: assert property (
      rd_b_addr_in[7:1] == 7'h00 |-> rd_b_data_out == 16'h0000) else $error("zero reg");
   AST_ZERO_FLAG: assert property (
      s_arith |=> psw_out[15] == ($past(flag_upd_in.result) == 16'h0000))
      else $error("zero flag");
   AST_CHAIN: assert property (
      s_upd ##0 flag_upd_in.op == oas_pkg::OAS_FLAG_ARITH_CHAIN |=>
      psw_out[15] == ($past(psw_out[15]) && $past(flag_upd_in.result) == 16'h0000))
      else $error("chain zero");
   AST_TRAP_SET: assert property (
      s_arith ##0 flag_upd_in.overflow |=> psw_out[13] && psw_out[12]) else $error("trap set");
   AST_TRAP_HOLD: assert property (
      psw_out[12] && !psw_pop_in && !trap_clear_in |=> psw_out[12]) else $error("trap hold");
   AST_POP: assert property (
      psw_pop_in |=> (psw_out & 16'hfbff) == ($past(psw_pop_data_in) & 16'hfbff))
      else $error("pop");
   AST_ROUND: assert property (
      s_upd ##0 flag_upd_in.op == oas_pkg::OAS_FLAG_SHIFT_RIGHT |=>
      psw_out[8] == $past(flag_upd_in.round_hint)) else $error("round hint");
   AST_TRAP_CLEAR: assert property (
      trap_clear_in && !psw_pop_in && !(flag_upd_in.valid && flag_upd_in.overflow) |=>
      !psw_out[12]) else $error("trap clear");
   AST_GATE: assert property (
      !psw_out[9] |-> !irq_take_out) else $error("gate");
   AST_MASK: assert property (
      irq_take_out |-> $onehot(irq_service_out) &&
      (irq_service_out & ~(psw_out[NUM_SRC-1:0] & irq_pending_out)) == '0) else $error("mask");
   AST_PENDING: assert property (
      |irq_req_in |=> (irq_pending_out & $past(irq_req_in)) == $past(irq_req_in))
      else $error("pending");
endmodule : oas_monitor

// file: verif/oas_alu_model.sv
/*
 Behavioural ALU of the decoder side: adds two words and forms flags.
 Assumes the bench supplies operands and the flag operation.
*/
`timescale 1ns/100ps
module oas_alu_model (
   input wire logic valid_in,
   input wire oas_pkg::oas_flag_op_e op_in,
   input wire logic [15:0] a_in,
   input wire logic [15:0] b_in,
   output oas_pkg::oas_flag_upd_s upd_out
);
   logic [16:0] sum;
   logic [3:0] shift_cnt;
   logic [15:0] off_mask;
   assign sum = {1'b0, a_in} + {1'b0, b_in};
   assign shift_cnt = b_in[3:0];
   // Bits that leave below the final carry position
   assign off_mask = ((16'h0001 << shift_cnt) - 16'h0001) >> 1;
   always_comb begin
      // Sign of the 17-bit true sum
      upd_out = '{valid_in, op_in, sum[15:0], sum[15:0] == 16'h0000,
         a_in[15] ^ b_in[15] ^ sum[16], (a_in[15] == b_in[15]) && (sum[15] != a_in[15]),
         sum[16], 1'b0};
      if (op_in == oas_pkg::OAS_FLAG_SHIFT_RIGHT) begin
         // Right shift of a by the low four bits of b
         upd_out.result = a_in >> shift_cnt;
         upd_out.zero = (a_in >> shift_cnt) == 16'h0000;
         upd_out.negative = 1'b0;
         upd_out.overflow = 1'b0;
         upd_out.carry = (shift_cnt != 4'h0) && a_in[shift_cnt - 4'h1];
         upd_out.round_hint = |(a_in & off_mask);
      end
   end
endmodule : oas_alu_model

// file: verif/testbench.sv
/*
 Directed bench for the operand address and status word block.
 Assumes the design package and header are compiled first.
*/
`timescale 1ns/100ps
module testbench;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   oas_pkg::oas_addr_req_s req = '0;
   oas_pkg::oas_flag_upd_s upd;
   oas_pkg::oas_flag_op_e alu_op = oas_pkg::OAS_FLAG_NONE;
   logic alu_v = 1'b0, wr_en = 1'b0, wr_word = 1'b0, trap_clr = 1'b0, pop = 1'b0;
   logic gw = 1'b0, gv = 1'b0, mem, take, av;
   logic [7:0] rd_b = 8'h00, rd_c = 8'h00, wr_addr = 8'h00, irq_req = 8'h00, irq_ack = 8'h00;
   logic [7:0] pend, serv;
   logic [15:0] alu_a = 16'h0000, alu_b = 16'h0000, wr_data = 16'h0000, pop_data = 16'h0000;
   logic [15:0] ea, opd, b_data, c_data, program_status_word;
   int error_cnt = 0;
   int checked = 0;
   oas_core uut (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_req_in(req), .eff_addr_out(ea),
      .operand_out(opd), .is_memory_out(mem), .addr_valid_out(av), .rd_b_addr_in(rd_b),
      .rd_c_addr_in(rd_c), .rd_b_data_out(b_data), .rd_c_data_out(c_data), .wr_en_in(wr_en),
      .wr_word_in(wr_word), .wr_addr_in(wr_addr), .wr_data_in(wr_data), .flag_upd_in(upd),
      .trap_clear_in(trap_clr), .psw_pop_in(pop), .psw_pop_data_in(pop_data),
      .gate_write_in(gw), .gate_value_in(gv), .psw_out(program_status_word), .irq_req_in(irq_req),
      .irq_ack_in(irq_ack), .irq_pending_out(pend), .irq_service_out(serv), .irq_take_out(take)
   );
   oas_alu_model u_alu (.valid_in(alu_v), .op_in(alu_op), .a_in(alu_a), .b_in(alu_b),
      .upd_out(upd));
   initial begin
      forever #50 clk_in = ~clk_in;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict
   // Held high between back-to-back calls; caller lowers it
   task automatic wr(input logic w, input logic [7:0] a, input logic [15:0] d);
      wr_en = 1'b1;
      wr_word = w;
      wr_addr = a;
      wr_data = d;
      @(negedge clk_in);
   endtask : wr
   task automatic rd(input logic [7:0] b, input logic [7:0] c, input logic [15:0] xb, xc);
      rd_b = b;
      rd_c = c;
      #1;
      chk(b_data, xb, "read b");
      chk(c_data, xc, "read c");
   endtask : rd
   task automatic rq(input oas_pkg::oas_mode_e m, input logic [7:0] s, input logic [15:0] f,
         input logic [15:0] x, input logic w = 1'b1);
      logic xm;
      xm = !(m inside {oas_pkg::OAS_MODE_DIRECT, oas_pkg::OAS_MODE_IMMEDIATE});
      req = '{1'b1, m, w, s, f};
      @(negedge clk_in);
      chk(xm ? ea : opd, x, "operand");
      chk({15'h0, mem}, {15'h0, xm}, "memory");
      chk({15'h0, av}, 16'h0001, "request valid");
   endtask : rq
   task automatic fl(input oas_pkg::oas_flag_op_e o, input logic [15:0] a, b,
         input logic [4:0] x);
      alu_v = 1'b1;
      alu_op = o;
      alu_a = a;
      alu_b = b;
      @(negedge clk_in);
      chk({11'h0, program_status_word[15:11]}, {11'h0, x}, "flags");
   endtask : fl
   task automatic ir(input logic [7:0] xp, xs, input logic xt);
      chk({pend, serv}, {xp, xs}, "irq");
      chk({15'h0, take}, {15'h0, xt}, "take");
   endtask : ir
   initial begin
      repeat (20) @(negedge clk_in);
      sys_rst_in = 1'b0;
      wr(1'b1, 8'h20, 16'h1234);
      wr(1'b0, 8'h21, 16'h0056);
      wr(1'b1, 8'h00, 16'hffff);
      wr(1'b1, 8'h18, 16'h0400);
      wr_en = 1'b0;
      rd(8'h20, 8'h18, 16'h5634, 16'h0400);
      rd(8'h00, 8'h01, 16'h0000, 16'h0000);
      $display("registers done");
      rq(oas_pkg::OAS_MODE_DIRECT, 8'h20, 16'h0000, 16'h5634);
      rq(oas_pkg::OAS_MODE_INDIRECT, 8'h20, 16'h0000, 16'h5634);
      rq(oas_pkg::OAS_MODE_SHORT_IDX, 8'h20, 16'h0080, 16'h55b4);
      rq(oas_pkg::OAS_MODE_SHORT_IDX, 8'h20, 16'h007f, 16'h56b3);
      rq(oas_pkg::OAS_MODE_LONG_IDX, 8'h20, 16'h8000, 16'hd634);
      rq(oas_pkg::OAS_MODE_LONG_IDX, 8'h00, 16'h4321, 16'h4321);
      rq(oas_pkg::OAS_MODE_IMMEDIATE, 8'h00, 16'hbeef, 16'hbeef);
      rq(oas_pkg::OAS_MODE_IMMEDIATE, 8'h00, 16'h00a5, 16'h00a5, 1'b0);
      rq(oas_pkg::OAS_MODE_AUTOINC, 8'h18, 16'h0000, 16'h0400);
      rq(oas_pkg::OAS_MODE_AUTOINC, 8'h18, 16'h0000, 16'h0402, 1'b0);
      req.valid = 1'b0;
      rd(8'h18, 8'h20, 16'h0403, 16'h5634);
      $display("addressing done");
      fl(oas_pkg::OAS_FLAG_ARITH, 16'h7fff, 16'h0001, 5'b00110);
      chk({15'h0, av}, 16'h0000, "request idle");
      fl(oas_pkg::OAS_FLAG_ARITH, 16'hffff, 16'h0001, 5'b10011);
      fl(oas_pkg::OAS_FLAG_ARITH_CHAIN, 16'h0000, 16'h0000, 5'b10010);
      fl(oas_pkg::OAS_FLAG_ARITH_CHAIN, 16'h0001, 16'h0001, 5'b00010);
      fl(oas_pkg::OAS_FLAG_ARITH, 16'h8000, 16'h8000, 5'b11111);
      alu_v = 1'b0;
      trap_clr = 1'b1;
      @(negedge clk_in);
      trap_clr = 1'b0;
      chk({15'h0, program_status_word[12]}, 16'h0000, "trap");
      fl(oas_pkg::OAS_FLAG_SHIFT_RIGHT, 16'h0007, 16'h0002, 5'b00001);
      chk({15'h0, program_status_word[8]}, 16'h0001, "round hint");
      fl(oas_pkg::OAS_FLAG_MULTIPLY, 16'h0003, 16'h0004, 5'b00000);
      chk({15'h0, program_status_word[8]}, 16'h0000, "round after multiply");
      alu_v = 1'b0;
      $display("flags done");
      gw = 1'b1;
      gv = 1'b1;
      wr(1'b0, 8'h08, 16'h0005);
      wr_en = 1'b0;
      gw = 1'b0;
      chk({6'h0, program_status_word[9:0]}, 16'h0205, "gate mask");
      irq_req = 8'h06;
      @(negedge clk_in);
      irq_req = 8'h00;
      ir(8'h06, 8'h04, 1'b1);
      irq_ack = 8'h04;
      @(negedge clk_in);
      irq_ack = 8'h00;
      ir(8'h02, 8'h00, 1'b0);
      pop = 1'b1;
      pop_data = 16'h80ff;
      @(negedge clk_in);
      pop = 1'b0;
      chk(program_status_word, 16'h80ff, "popped word");
      ir(8'h02, 8'h00, 1'b0);
      gw = 1'b1;
      @(negedge clk_in);
      gw = 1'b0;
      ir(8'h02, 8'h02, 1'b1);
      $display("interrupt gating done");
      give_verdict();
   end
   initial begin
      repeat (2000) @(posedge clk_in);
      error_cnt++;
      give_verdict();
   end
endmodule : testbench
bind oas_core oas_monitor #(.NUM_SRC(NUM_SRC)) u_mon (
   .clk_in(clk_in), .sys_rst_in(sys_rst_in), .rd_b_addr_in(rd_b_addr_in),
   .rd_b_data_out(rd_b_data_out), .flag_upd_in(flag_upd_in), .trap_clear_in(trap_clear_in),
   .psw_pop_in(psw_pop_in), .psw_pop_data_in(psw_pop_data_in), .gate_write_in(gate_write_in),
   .psw_out(psw_out), .irq_req_in(irq_req_in), .irq_pending_out(irq_pending_out),
   .irq_service_out(irq_service_out), .irq_take_out(irq_take_out)
);
